//--- fsi_map.svh
// constants of the flow sensor two-wire read-out slave
`ifndef FSI_MAP_SVH
`define FSI_MAP_SVH

`define FSI_SLAVE_ADDR 7'h50
`define FSI_DIR_READ 1'h1
`define FSI_BITS_PER_BYTE 4'h8
`define FSI_COUNT_ZERO 12'h199
`define FSI_COUNT_FULL 12'hE66
`define FSI_FILL_BYTE 8'h00
`define FSI_IDX_CKS 2'h0
`define FSI_IDX_HIGH 2'h1
`define FSI_IDX_LOW 2'h2
`define FSI_SYNC_RST 3'h7
`define FSI_CNT_RST 4'h0
`define FSI_BYTE_RST 8'h00
`define FSI_WORD_RST 12'h000
`define FSI_IDX_RST 2'h0

`endif

//--- fsi_pkg.sv
// types of the flow sensor two-wire read-out slave
`default_nettype none

package fsi_pkg;

    typedef enum logic [2:0] {
        FSI_IDLE     = 3'b000,
        FSI_ADDR     = 3'b001,
        FSI_ADDR_ACK = 3'b010,
        FSI_TX       = 3'b011,
        FSI_TX_ACK   = 3'b100,
        FSI_IGNORE   = 3'b101
    } fsi_phase_t;

    // open-drain data pin: level driven and its active-low enable
    typedef struct packed {
        logic lvl;
        logic oe_n;
    } fsi_pin_t;

    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        logic scl_f;
        logic sda_f;
        fsi_phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [1:0] byte_idx;
        logic [11:0] count;
        logic [7:0] cks;
        logic ack;
        logic sda_oe_n;
    } fsi_state_t;

endpackage : fsi_pkg

`default_nettype wire

//--- fsi_slave.sv
// two-wire slave that returns checksum and flow count on a read
// Overview of operation
// R1: answer only a 7-bit address equal to 50 hex, ignore any other.
// R2: act only as slave and keep up with a 100kHz or 400kHz bus clock.
// R3: a falling data line while the clock is high is a start.
// R4: a rising data line while the clock is high is a stop, go idle.
// R5: each byte is 8 bits plus a response bit, low ack and high nack.
// R6: after an ack the master sends another byte or a stop.
// R7: after a byte addressed to us, pull data low for the response bit; the code does so only for a read address, a write gets none.
// R8: the master reads a released data line in the response slot as nack.
// R9: sample data on clock rise, change it only while the clock is low.
// R10: the data line is only pulled low or released, never driven high.
// R11: the count is 409 at zero flow and 3686 at full scale, linear.
// R12: a read is start, the 7-bit address and a direction bit of one.
// R13: a read returns checksum, then high and low flow byte, msb first.
// R14: the flow is 12 bits; the top four bits of the high byte are void.
// R15: the checksum is minus the 8-bit sum of the two flow bytes.
// R16: count and checksum are caught once when the address matches.
// R17: keep data released after a mismatched address until next start.
`timescale 1ns/1ps
`default_nettype none
`include "fsi_map.svh"

module fsi_slave
    import fsi_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output var fsi_pin_t sda_o,
    // sensing side
    input wire logic [11:0] flow_count_output_i
);

    fsi_state_t s_q;
    fsi_state_t s_d;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [11:0] count_now;
    logic [7:0] cks_now;

    // pick the byte at a given position of the read frame
    function automatic logic [7:0] frame_byte(input logic [1:0] idx,
        input logic [11:0] cnt, input logic [7:0] cks);
        logic [7:0] b;
        b = `FSI_FILL_BYTE;
        unique case (idx)
            `FSI_IDX_CKS: b = cks; // R13
            `FSI_IDX_HIGH: b = {4'h0, cnt[11:8]}; // R14
            `FSI_IDX_LOW: b = cnt[7:0];
            default: b = `FSI_FILL_BYTE;
        endcase
        return b;
    endfunction : frame_byte

    // sensing path is trusted for linearity, only the end points are held
    always_comb begin
        if (flow_count_output_i < `FSI_COUNT_ZERO) begin
            count_now = `FSI_COUNT_ZERO; // R11
        end else if (flow_count_output_i > `FSI_COUNT_FULL) begin
            count_now = `FSI_COUNT_FULL; // R11
        end else begin
            count_now = flow_count_output_i;
        end
        cks_now = 8'(8'h00 - ({4'h0, count_now[11:8]} + count_now[7:0])); // R15
    end

    always_comb begin
        s_d = s_q;
        // first stage feeds only the second; filter looks at 2nd and 3rd
        // filter delay is a few system clocks, far below either bus rate
        s_d.scl_sy = {s_q.scl_sy[1:0], scl_i}; // R2
        s_d.sda_sy = {s_q.sda_sy[1:0], sda_i};
        if (s_q.scl_sy[1] == s_q.scl_sy[2]) begin
            s_d.scl_f = s_q.scl_sy[2];
        end
        if (s_q.sda_sy[1] == s_q.sda_sy[2]) begin
            s_d.sda_f = s_q.sda_sy[2];
        end
        scl_rise = !s_q.scl_f && s_d.scl_f; // R9
        scl_fall = s_q.scl_f && !s_d.scl_f;
        start_ev = s_q.scl_f && s_d.scl_f && s_q.sda_f && !s_d.sda_f; // R3
        stop_ev = s_q.scl_f && s_d.scl_f && !s_q.sda_f && s_d.sda_f; // R4

        if (start_ev) begin
            s_d.phase = FSI_ADDR; // R3
            s_d.bit_cnt = `FSI_CNT_RST;
            s_d.sda_oe_n = 1'b1;
        end else if (stop_ev) begin
            s_d.phase = FSI_IDLE; // R4
            s_d.sda_oe_n = 1'b1;
        end else begin
            unique case (s_q.phase)
                FSI_IDLE, FSI_IGNORE: begin
                    s_d.sda_oe_n = 1'b1; // R17
                end
                FSI_ADDR: begin
                    if (scl_rise) begin
                        s_d.shift = {s_q.shift[6:0], s_d.sda_f}; // R9
                        s_d.bit_cnt = 4'(s_q.bit_cnt + 4'h1);
                    end else if (scl_fall &&
                                 s_q.bit_cnt == `FSI_BITS_PER_BYTE) begin // R5
                        // a write to us is refused: nothing to receive
                        if (s_q.shift[7:1] == `FSI_SLAVE_ADDR &&
                            s_q.shift[0] == `FSI_DIR_READ) begin // R1 R12
                            s_d.phase = FSI_ADDR_ACK;
                            s_d.sda_oe_n = 1'b0; // R7
                            s_d.count = count_now; // R16
                            s_d.cks = cks_now; // R16
                        end else begin
                            s_d.phase = FSI_IGNORE; // R17
                        end
                    end
                end
                FSI_ADDR_ACK: begin
                    if (scl_fall) begin
                        s_d.phase = FSI_TX;
                        s_d.byte_idx = `FSI_IDX_CKS;
                        s_d.shift = frame_byte(`FSI_IDX_CKS, s_q.count,
                                               s_q.cks); // R13
                        s_d.sda_oe_n = s_d.shift[7]; // R10
                        s_d.bit_cnt = `FSI_CNT_RST;
                    end
                end
                FSI_TX: begin
                    if (scl_rise) begin
                        s_d.bit_cnt = 4'(s_q.bit_cnt + 4'h1);
                    end else if (scl_fall) begin
                        if (s_q.bit_cnt == `FSI_BITS_PER_BYTE) begin
                            s_d.phase = FSI_TX_ACK; // R5
                            s_d.sda_oe_n = 1'b1;
                        end else begin
                            s_d.shift = {s_q.shift[6:0], 1'b0};
                            s_d.sda_oe_n = s_d.shift[7]; // R9 R10
                        end
                    end
                end
                FSI_TX_ACK: begin
                    if (scl_rise) begin
                        s_d.ack = !s_d.sda_f; // R8
                    end else if (scl_fall) begin
                        if (s_q.ack) begin
                            // past the low byte the frame pads with fill
                            s_d.byte_idx = (s_q.byte_idx == `FSI_IDX_LOW) ?
                                s_q.byte_idx + 2'h1 : 2'(s_q.byte_idx + 2'h1);
                            if (s_q.byte_idx == 2'h3) begin
                                s_d.byte_idx = 2'h3;
                            end
                            s_d.shift = frame_byte(s_d.byte_idx, s_q.count,
                                                   s_q.cks); // R6 R13
                            s_d.sda_oe_n = s_d.shift[7];
                            s_d.bit_cnt = `FSI_CNT_RST;
                            s_d.phase = FSI_TX;
                        end else begin
                            s_d.phase = FSI_IGNORE; // R8
                        end
                    end
                end
                default: begin
                    s_d.phase = FSI_IDLE;
                    s_d.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q.scl_sy <= `FSI_SYNC_RST;
            s_q.sda_sy <= `FSI_SYNC_RST;
            s_q.scl_f <= 1'b1;
            s_q.sda_f <= 1'b1;
            s_q.phase <= FSI_IDLE;
            s_q.bit_cnt <= `FSI_CNT_RST;
            s_q.shift <= `FSI_BYTE_RST;
            s_q.byte_idx <= `FSI_IDX_RST;
            s_q.count <= `FSI_WORD_RST;
            s_q.cks <= `FSI_BYTE_RST;
            s_q.ack <= 1'b0;
            s_q.sda_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // only ever pull low; the enable alone decides the wire
    assign sda_o.lvl = 1'b0; // R10
    assign sda_o.oe_n = s_q.sda_oe_n;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_start_to_addr: assert property (start_ev |=> s_q.phase == FSI_ADDR) // R3
        else $error("start did not open address phase");
    a_stop_to_idle: assert property (stop_ev |=> s_q.phase == FSI_IDLE // R4
        && s_q.sda_oe_n) else $error("stop did not idle the slave");
    a_addr_mismatch: assert property ( // R1
        s_q.phase == FSI_ADDR && scl_fall && !start_ev && !stop_ev &&
        s_q.bit_cnt == 4'h8 && s_q.shift[7:1] != `FSI_SLAVE_ADDR
        |=> s_q.phase == FSI_IGNORE && s_q.sda_oe_n)
        else $error("foreign address was not ignored");
    a_ack_drive: assert property ( // R7
        $rose(s_q.phase == FSI_ADDR_ACK) |-> !s_q.sda_oe_n &&
        $past(s_q.shift) == 8'hA1) else $error("address ack not driven");
    a_ignore_released: assert property ( // R17
        s_q.phase == FSI_IGNORE |-> s_q.sda_oe_n)
        else $error("data driven while ignoring");
    a_change_scl_low: assert property ( // R9
        $fell(s_q.sda_oe_n) && s_q.phase != FSI_ADDR_ACK |-> !s_q.scl_f)
        else $error("data pulled low while clock high");
    a_checksum_zero: assert property ( // R15
        s_q.phase == FSI_TX |-> 8'(s_q.cks + {4'h0, s_q.count[11:8]} +
        s_q.count[7:0]) == 8'h00) else $error("checksum does not cancel");
    a_count_range: assert property ( // R11
        s_q.phase == FSI_TX |-> s_q.count >= `FSI_COUNT_ZERO &&
        s_q.count <= `FSI_COUNT_FULL) else $error("count out of nominal range");
    a_sample_held: assert property ( // R16
        s_q.phase == FSI_TX && $past(s_q.phase) == FSI_TX
        |-> $stable(s_q.count) && $stable(s_q.cks))
        else $error("sample changed inside a frame");
    a_first_byte: assert property ( // R13
        s_q.phase == FSI_ADDR_ACK && scl_fall && !start_ev && !stop_ev
        |=> s_q.shift == s_q.cks && s_q.sda_oe_n == s_q.cks[7])
        else $error("frame did not open with checksum");
    a_high_nibble: assert property ( // R14
        s_q.phase == FSI_TX && s_q.byte_idx == 2'h1 && s_q.bit_cnt == 4'h0
        |-> s_q.shift[7:4] == 4'h0) else $error("void nibble not zero");
    a_bit_count: assert property ( // R5
        s_q.bit_cnt <= 4'h8) else $error("more than eight bits counted");

endmodule : fsi_slave

`default_nettype wire

//--- fsi_master_model.sv
// bus master model that fetches readings over the two-wire bus
`timescale 1ns/1ps
`default_nettype none

module fsi_master_model (
    // clock
    input wire logic clk_i,
    // bus wires
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // a released line reads high through the pull-up
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // data set mid-low, held over the whole high phase
    task automatic bit_cycle(input logic b, output logic rd);
        sda_o <= b;
        tick(4);
        scl_o <= 1'h1;
        tick(4);
        rd = sda_i;
        tick(4);
        scl_o <= 1'h0;
        tick(4);
    endtask : bit_cycle

    // also a repeated start when entered with the clock low
    task automatic start();
        sda_o <= 1'h1;
        tick(4);
        scl_o <= 1'h1;
        tick(4);
        sda_o <= 1'h0;
        tick(4);
        scl_o <= 1'h0;
        tick(4);
    endtask : start

    task automatic stop();
        sda_o <= 1'h0;
        tick(4);
        scl_o <= 1'h1;
        tick(4);
        sda_o <= 1'h1;
        tick(8);
    endtask : stop

    // high in the response slot reads as not-acknowledge
    task automatic xfer(input logic [7:0] wr, input logic mack,
                        output logic [7:0] rd, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(wr[i], rd[i]);
        end
        bit_cycle(mack, ack);
    endtask : xfer
endmodule : fsi_master_model

`default_nettype wire

//--- fsi_slave_bench.sv
// self-checking bench of the flow sensor two-wire slave
`timescale 1ns/1ps
`default_nettype none

module fsi_slave_bench;
    import fsi_pkg::*;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [11:0] flow_q = 12'h000;
    logic scl_w;
    logic m_sda;
    logic sda_w;
    fsi_pin_t pin;
    int n_errors = 0;
    int tests_run = 0;

    always #2.5 clk_i = ~clk_i;
    // a slave driving its level high would not pull the wire down
    assign sda_w = m_sda & (pin.oe_n | pin.lvl);

    fsi_slave u_fsi_slave (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_w),
        .sda_i(sda_w), .sda_o(pin), .flow_count_output_i(flow_q));
    fsi_master_model u_fsi_master_model (.clk_i(clk_i), .sda_i(sda_w),
        .scl_o(scl_w), .sda_o(m_sda));

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [11:0] clamp(input logic [11:0] v);
        return v < 12'h199 ? 12'h199 : (v > 12'hE66 ? 12'hE66 : v);
    endfunction : clamp

    // changes the input after the address so a late sample shows up
    task automatic read_frame(input logic [11:0] smp, input logic [11:0] late);
        logic [11:0] c;
        logic [7:0] rd;
        logic [7:0] hi;
        logic ack;
        c = clamp(smp);
        hi = {4'h0, c[11:8]};
        flow_q <= smp;
        u_fsi_master_model.start();
        u_fsi_master_model.xfer(8'hA1, 1'h1, rd, ack);
        check("address ack", {7'h00, ack}, 8'h00);
        flow_q <= late;
        u_fsi_master_model.xfer(8'hFF, 1'h0, rd, ack);
        check("checksum", rd, 8'h00 - hi - c[7:0]);
        u_fsi_master_model.xfer(8'hFF, 1'h0, rd, ack);
        check("high byte", rd, hi);
        u_fsi_master_model.xfer(8'hFF, 1'h0, rd, ack);
        check("low byte", rd, c[7:0]);
        u_fsi_master_model.xfer(8'hFF, 1'h1, rd, ack);
        check("fill byte", rd, 8'h00);
        u_fsi_master_model.stop();
    endtask : read_frame

    task automatic test_frame();
        read_frame(12'h5A3, 12'h2B4);
        $display("test frame done");
    endtask : test_frame

    task automatic test_range();
        logic [11:0] v[5] = '{12'h000, 12'h199, 12'h800, 12'hE66, 12'hFFF};
        foreach (v[i]) begin
            read_frame(v[i], v[i]);
        end
        $display("test range done");
    endtask : test_range

    // wrong address or a write: no ack and the line stays released
    task automatic test_foreign();
        logic [7:0] a[3] = '{8'hA3, 8'hA0, 8'h21};
        logic [7:0] rd;
        logic ack;
        flow_q <= 12'h000;
        foreach (a[i]) begin
            u_fsi_master_model.start();
            u_fsi_master_model.xfer(a[i], 1'h1, rd, ack);
            check("foreign ack", {7'h00, ack}, 8'h01);
            u_fsi_master_model.xfer(8'hFF, 1'h1, rd, ack);
            check("foreign data", rd, 8'hFF);
            u_fsi_master_model.stop();
        end
        $display("test foreign done");
    endtask : test_foreign

    // nack after the checksum, then a repeated start with no stop
    task automatic test_restart();
        logic [7:0] rd;
        logic ack;
        flow_q <= 12'h321;
        u_fsi_master_model.start();
        u_fsi_master_model.xfer(8'hA1, 1'h1, rd, ack);
        u_fsi_master_model.xfer(8'hFF, 1'h1, rd, ack);
        check("first checksum", rd, 8'hDC);
        read_frame(12'h7C4, 12'h123);
        $display("test restart done");
    endtask : test_restart

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (8) @(posedge clk_i);
        test_frame();
        test_range();
        test_foreign();
        test_restart();
        wrap_up();
    end

    // all frames together take well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        wrap_up();
    end
endmodule : fsi_slave_bench

`default_nettype wire
